// >>> verilog/mcg_pkg.sv
/*
  Shared constants and types of the metering compute and gain config bank.
  Assumes APB with 32-bit data; registers sit at four times their index.
*/
`default_nettype none

package mcg_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int MCG_ADDR_W   = 20;
  localparam int MCG_DATA_W   = 32;
  localparam int MCG_REG_W    = 16;
  localparam int MCG_SAMPLE_W = 16;
  localparam int MCG_GAINED_W = 20;
  localparam int MCG_POWER_W  = 24;
  localparam int MCG_SUM_W    = 26;
  localparam int MCG_ACC_W    = 32;
  localparam int MCG_RMS_W    = 24;

  // ---------------------------------------------------------------
  // Register map: printed indices, byte address is four times index
  // ---------------------------------------------------------------
  localparam logic [15:0] MCG_IDX_COMPUTATION_MODE = 16'he60e;
  localparam logic [15:0] MCG_IDX_INPUT_GAIN       = 16'he60f;
  localparam logic [MCG_ADDR_W-1:0] MCG_ADDR_COMPUTATION_MODE =
    {2'h0, MCG_IDX_COMPUTATION_MODE, 2'h0};
  localparam logic [MCG_ADDR_W-1:0] MCG_ADDR_INPUT_GAIN =
    {2'h0, MCG_IDX_INPUT_GAIN, 2'h0};

  // ---------------------------------------------------------------
  // Reset values and writable bits
  // ---------------------------------------------------------------
  localparam logic [MCG_REG_W-1:0] MCG_COMPUTATION_MODE_RST  = 16'h01ff;
  localparam logic [MCG_REG_W-1:0] MCG_COMPUTATION_MODE_MASK = 16'h7fff;
  localparam logic [MCG_REG_W-1:0] MCG_GAIN_RST      = 16'h0000;
  localparam logic [MCG_REG_W-1:0] MCG_GAIN_MASK     = 16'h01ff;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int MCG_POS_PULSE_ONE   = 0;
  localparam int MCG_POS_PULSE_TWO   = 3;
  localparam int MCG_POS_PULSE_THREE = 6;
  localparam int MCG_POS_ANGLE       = 9;
  localparam int MCG_POS_NOMINAL     = 11;
  localparam int MCG_POS_LINE_FREQ   = 14;
  localparam int MCG_POS_I_GAIN      = 0;
  localparam int MCG_POS_N_GAIN      = 3;
  localparam int MCG_POS_V_GAIN      = 6;

  // Highest legal gain code, gain 16
  localparam logic [2:0] MCG_GAIN_CODE_MAX = 3'h4;
  // Accumulated energy per output pulse
  localparam logic [MCG_ACC_W-1:0] MCG_PULSE_THRESHOLD = 32'h0100_0000;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MCG_ANGLE_V_TO_I = 2'h0,
    MCG_ANGLE_V_TO_V = 2'h1,
    MCG_ANGLE_I_TO_I = 2'h2,
    MCG_ANGLE_OFF    = 2'h3
  } mcg_angle_t;

  typedef struct packed {
    logic             spare;
    logic             line_frequency_select;
    logic [2:0]       nominal_voltage_use;
    mcg_angle_t       angle_measure_select;
    logic [2:0]       pulse_three_phase_include;
    logic [2:0]       pulse_two_phase_include;
    logic [2:0]       pulse_one_phase_include;
  } mcg_computation_mode_t;

  typedef struct packed {
    logic [6:0]       spare;
    logic [2:0]       phase_voltage_gain;
    logic [2:0]       neutral_current_gain;
    logic [2:0]       phase_current_gain;
  } mcg_gain_t;

  typedef struct packed {
    logic                    psel;
    logic                    penable;
    logic                    pwrite;
    logic [MCG_ADDR_W-1:0]   paddr;
    logic [MCG_DATA_W-1:0]   pwdata;
    logic [3:0]              pstrb;
  } mcg_apb_req_t;

  typedef struct packed {
    logic                    pready;
    logic                    pslverr;
    logic [MCG_DATA_W-1:0]   prdata;
  } mcg_apb_rsp_t;

endpackage : mcg_pkg

`default_nettype wire

// >>> verilog/mcg_gain_stage.sv
/*
  One analog input gain stage: folds reserved codes and scales a sample.
  Assumes samples and code come from logic on pclk.
*/
`default_nettype none

module mcg_gain_stage
  import mcg_pkg::*;
(
  // Clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // Sample in
  input  wire logic [2:0]              gain_code,
  input  wire logic [MCG_SAMPLE_W-1:0] sample_in,
  // Scaled sample out
  output logic      [MCG_GAINED_W-1:0] sample_out
);

  // -----------------------------------------------------------------
  // Gain fold
  // -----------------------------------------------------------------
  logic [2:0] shift;

  // Reserved codes behave as unity gain
  assign shift = (gain_code > MCG_GAIN_CODE_MAX) ? 3'h0 : gain_code;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_out <= '0;
    end else begin
      sample_out <= MCG_GAINED_W'({4'h0, sample_in} << shift);
    end
  end

endmodule : mcg_gain_stage

`default_nettype wire

// >>> verilog/mcg_phase_sum.sv
/*
  Sum of per-phase power over the phases a pulse output includes.
  Assumes power values are unsigned magnitudes on pclk.
*/
`default_nettype none

module mcg_phase_sum
  import mcg_pkg::*;
(
  // Clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // Phase selection and powers
  input  wire logic [2:0]             phase_include,
  input  wire logic [MCG_POWER_W-1:0] power_a,
  input  wire logic [MCG_POWER_W-1:0] power_b,
  input  wire logic [MCG_POWER_W-1:0] power_c,
  // Selected sum
  output logic      [MCG_SUM_W-1:0]   power_sum
);

  // -----------------------------------------------------------------
  // Masked sum
  // -----------------------------------------------------------------
  logic [MCG_SUM_W-1:0] term_a;
  logic [MCG_SUM_W-1:0] term_b;
  logic [MCG_SUM_W-1:0] term_c;

  assign term_a = phase_include[0] ? {2'h0, power_a} : '0;
  assign term_b = phase_include[1] ? {2'h0, power_b} : '0;
  assign term_c = phase_include[2] ? {2'h0, power_c} : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_sum <= '0;
    end else begin
      power_sum <= term_a + term_b + term_c;
    end
  end

endmodule : mcg_phase_sum

`default_nettype wire

// >>> verilog/mcg_config_top.sv
/*
  Computation-mode and input-gain register bank with the logic it steers:
  gain stages, nominal voltage substitution, angle selection, pulse sums.
  Assumes an APB master on pclk and a measurement datapath on pclk.
*/
// Notes on behaviour
// - Bits 0-2 add phases into pulse one
// - Bits 3-5 add phases into pulse two
// - Bits 6-8 add phases into pulse three
// - Bits 10:9 choose which angles measure
// - Nominal enable clear uses measured rms
// - Bit 11 swaps phase A rms for nominal
// - Bit 12 swaps phase B rms for nominal
// - Bit 13 swaps phase C rms for nominal
// - Bit 15 reads zero, controls nothing
// - Current gain field codes give 1 to 16
// - Reserved gain codes act as unity
// - Neutral gain field at bits 5:3
// - Voltage gain field at bits 8:6
// - Gain bits 15:9 read zero, inert
// - Pulse rate follows sum of included phases
`default_nettype none

module mcg_config_top
  import mcg_pkg::*;
(
  // Clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // APB slave
  input  wire mcg_apb_req_t            apb_req,
  output mcg_apb_rsp_t                 apb_rsp,
  // Raw samples: currents a b c, neutral, voltages a b c
  input  wire logic [MCG_SAMPLE_W-1:0] current_sample_a,
  input  wire logic [MCG_SAMPLE_W-1:0] current_sample_b,
  input  wire logic [MCG_SAMPLE_W-1:0] current_sample_c,
  input  wire logic [MCG_SAMPLE_W-1:0] neutral_sample,
  input  wire logic [MCG_SAMPLE_W-1:0] voltage_sample_a,
  input  wire logic [MCG_SAMPLE_W-1:0] voltage_sample_b,
  input  wire logic [MCG_SAMPLE_W-1:0] voltage_sample_c,
  // Scaled samples
  output logic      [MCG_GAINED_W-1:0] current_scaled_a,
  output logic      [MCG_GAINED_W-1:0] current_scaled_b,
  output logic      [MCG_GAINED_W-1:0] current_scaled_c,
  output logic      [MCG_GAINED_W-1:0] neutral_scaled,
  output logic      [MCG_GAINED_W-1:0] voltage_scaled_a,
  output logic      [MCG_GAINED_W-1:0] voltage_scaled_b,
  output logic      [MCG_GAINED_W-1:0] voltage_scaled_c,
  // Rms voltage path
  input  wire logic [MCG_RMS_W-1:0]    nominal_voltage_value,
  input  wire logic [MCG_RMS_W-1:0]    measured_rms_a,
  input  wire logic [MCG_RMS_W-1:0]    measured_rms_b,
  input  wire logic [MCG_RMS_W-1:0]    measured_rms_c,
  output logic      [MCG_RMS_W-1:0]    effective_rms_a,
  output logic      [MCG_RMS_W-1:0]    effective_rms_b,
  output logic      [MCG_RMS_W-1:0]    effective_rms_c,
  output logic      [2:0]              voltage_input_ignored,
  // Angle measurement and line frequency
  output logic                         angle_voltage_to_current,
  output logic                         angle_voltage_to_voltage,
  output logic                         angle_current_to_current,
  output logic                         line_frequency_select,
  // Per-phase power for each pulse output
  input  wire logic [MCG_POWER_W-1:0]  pulse_power_a [3],
  input  wire logic [MCG_POWER_W-1:0]  pulse_power_b [3],
  input  wire logic [MCG_POWER_W-1:0]  pulse_power_c [3],
  // Pulse outputs and their sums
  output logic      [MCG_SUM_W-1:0]    pulse_power_sum [3],
  output logic                         pulse_output_one,
  output logic                         pulse_output_two,
  output logic                         pulse_output_three
);

  // -----------------------------------------------------------------
  // APB decode
  // -----------------------------------------------------------------
  logic                  setup_phase;
  logic                  access_phase;
  logic                  hit_computation_mode;
  logic                  hit_gain;
  logic                  hit_any;
  logic                  write_computation_mode;
  logic                  write_gain;
  logic [MCG_REG_W-1:0]  lane_mask;

  assign setup_phase  = apb_req.psel && !apb_req.penable;
  assign access_phase = apb_req.psel && apb_req.penable;
  assign hit_computation_mode = apb_req.paddr == MCG_ADDR_COMPUTATION_MODE;
  assign hit_gain     = apb_req.paddr == MCG_ADDR_INPUT_GAIN;
  assign hit_any      = hit_computation_mode || hit_gain;

  // Only the two low byte lanes carry register bits
  assign lane_mask = {{8{apb_req.pstrb[1]}}, {8{apb_req.pstrb[0]}}};

  // Unmapped writes are refused, nothing is stored
  assign write_computation_mode = access_phase && apb_req.pwrite && hit_computation_mode;
  assign write_gain     = access_phase && apb_req.pwrite && hit_gain;

  // -----------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------
  logic [MCG_REG_W-1:0] computation_mode_reg;
  logic [MCG_REG_W-1:0] computation_mode_next;
  logic [MCG_REG_W-1:0] input_gain_reg;
  logic [MCG_REG_W-1:0] input_gain_next;
  logic [MCG_REG_W-1:0] write_data;

  assign write_data = apb_req.pwdata[MCG_REG_W-1:0];

  // Reserved bits never store, so they always read zero
  assign computation_mode_next =
    (computation_mode_reg & ~(lane_mask & MCG_COMPUTATION_MODE_MASK)) |
    (write_data & lane_mask & MCG_COMPUTATION_MODE_MASK);
  assign input_gain_next =
    (input_gain_reg & ~(lane_mask & MCG_GAIN_MASK)) |
    (write_data & lane_mask & MCG_GAIN_MASK);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      computation_mode_reg <= MCG_COMPUTATION_MODE_RST;
    end else if (write_computation_mode) begin
      computation_mode_reg <= computation_mode_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_gain_reg <= MCG_GAIN_RST;
    end else if (write_gain) begin
      input_gain_reg <= input_gain_next;
    end
  end

  // -----------------------------------------------------------------
  // Read path
  // -----------------------------------------------------------------
  // Read data is captured in setup so it is a flop during access
  logic [MCG_REG_W-1:0]  read_select;
  logic [MCG_DATA_W-1:0] read_data_reg;

  assign read_select = hit_computation_mode ? computation_mode_reg :
                       hit_gain     ? input_gain_reg : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_data_reg <= '0;
    end else if (setup_phase) begin
      read_data_reg <= {16'h0000, read_select};
    end
  end

  // Zero wait states; error only for an unmapped address
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = access_phase && !hit_any;
  assign apb_rsp.prdata  = read_data_reg;

  // -----------------------------------------------------------------
  // Field views
  // -----------------------------------------------------------------
  mcg_computation_mode_t mode;
  mcg_gain_t     gain;

  assign mode = mcg_computation_mode_t'(computation_mode_reg);
  assign gain = mcg_gain_t'(input_gain_reg);

  // -----------------------------------------------------------------
  // Angle measurement and line frequency
  // -----------------------------------------------------------------
  assign angle_voltage_to_current =
    mode.angle_measure_select == MCG_ANGLE_V_TO_I;
  assign angle_voltage_to_voltage =
    mode.angle_measure_select == MCG_ANGLE_V_TO_V;
  assign angle_current_to_current =
    mode.angle_measure_select == MCG_ANGLE_I_TO_I;

  // Only carried out; the host picks the value for its mains
  assign line_frequency_select = mode.line_frequency_select;

  // -----------------------------------------------------------------
  // Gain stages
  // -----------------------------------------------------------------
  logic [MCG_SAMPLE_W-1:0] raw_sample    [7];
  logic [MCG_GAINED_W-1:0] scaled_sample [7];
  logic [2:0]              stage_code    [7];

  assign raw_sample[0] = current_sample_a;
  assign raw_sample[1] = current_sample_b;
  assign raw_sample[2] = current_sample_c;
  assign raw_sample[3] = neutral_sample;
  assign raw_sample[4] = voltage_sample_a;
  assign raw_sample[5] = voltage_sample_b;
  assign raw_sample[6] = voltage_sample_c;

  assign stage_code[0] = gain.phase_current_gain;
  assign stage_code[1] = gain.phase_current_gain;
  assign stage_code[2] = gain.phase_current_gain;
  assign stage_code[3] = gain.neutral_current_gain;
  assign stage_code[4] = gain.phase_voltage_gain;
  assign stage_code[5] = gain.phase_voltage_gain;
  assign stage_code[6] = gain.phase_voltage_gain;

  // Each stage folds codes above 100 back to unity
  generate
    for (genvar g = 0; g < 7; g++) begin : g_gain
      mcg_gain_stage u_stage (
        .pclk       (pclk),
        .presetn    (presetn),
        .gain_code  (stage_code[g]),
        .sample_in  (raw_sample[g]),
        .sample_out (scaled_sample[g])
      );
    end
  endgenerate

  assign current_scaled_a = scaled_sample[0];
  assign current_scaled_b = scaled_sample[1];
  assign current_scaled_c = scaled_sample[2];
  assign neutral_scaled   = scaled_sample[3];
  assign voltage_scaled_a = scaled_sample[4];
  assign voltage_scaled_b = scaled_sample[5];
  assign voltage_scaled_c = scaled_sample[6];

  // -----------------------------------------------------------------
  // Nominal voltage substitution
  // -----------------------------------------------------------------
  logic [MCG_RMS_W-1:0] measured_rms  [3];
  logic [MCG_RMS_W-1:0] effective_rms [3];

  assign measured_rms[0] = measured_rms_a;
  assign measured_rms[1] = measured_rms_b;
  assign measured_rms[2] = measured_rms_c;

  // One flop of latency on both choices keeps the switch glitch free
  generate
    for (genvar p = 0; p < 3; p++) begin : g_rms
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          effective_rms[p] <= '0;
        end else if (mode.nominal_voltage_use[p]) begin
          effective_rms[p] <= nominal_voltage_value;
        end else begin
          effective_rms[p] <= measured_rms[p];
        end
      end
    end
  endgenerate

  assign effective_rms_a = effective_rms[0];
  assign effective_rms_b = effective_rms[1];
  assign effective_rms_c = effective_rms[2];

  // Tells the datapath to ignore the voltage input of a phase
  assign voltage_input_ignored = mode.nominal_voltage_use;

  // -----------------------------------------------------------------
  // Pulse outputs
  // -----------------------------------------------------------------
  logic [2:0]           phase_include [3];
  logic [MCG_SUM_W-1:0] power_sum     [3];
  logic [MCG_ACC_W-1:0] energy_acc    [3];
  logic [MCG_ACC_W-1:0] energy_next   [3];
  logic [2:0]           pulse_reg;

  assign phase_include[0] = mode.pulse_one_phase_include;
  assign phase_include[1] = mode.pulse_two_phase_include;
  assign phase_include[2] = mode.pulse_three_phase_include;

  // Rate is set by a fixed threshold; coarse but keeps the sum exact
  generate
    for (genvar k = 0; k < 3; k++) begin : g_pulse
      mcg_phase_sum u_sum (
        .pclk          (pclk),
        .presetn       (presetn),
        .phase_include (phase_include[k]),
        .power_a       (pulse_power_a[k]),
        .power_b       (pulse_power_b[k]),
        .power_c       (pulse_power_c[k]),
        .power_sum     (power_sum[k])
      );

      assign energy_next[k] =
        energy_acc[k] + {6'h00, power_sum[k]};

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          energy_acc[k] <= '0;
          pulse_reg[k]  <= 1'b0;
        end else if (energy_next[k] >= MCG_PULSE_THRESHOLD) begin
          energy_acc[k] <= energy_next[k] - MCG_PULSE_THRESHOLD;
          pulse_reg[k]  <= 1'b1;
        end else begin
          energy_acc[k] <= energy_next[k];
          pulse_reg[k]  <= 1'b0;
        end
      end

      assign pulse_power_sum[k] = power_sum[k];
    end
  endgenerate

  assign pulse_output_one   = pulse_reg[0];
  assign pulse_output_two   = pulse_reg[1];
  assign pulse_output_three = pulse_reg[2];

endmodule : mcg_config_top

`default_nettype wire

// >>> verif/mcg_host.sv
/*
  Host model: APB master that writes and reads configuration words.
  Assumes pclk from the bench and a slave that may add wait states.
*/
`default_nettype none

module mcg_host
  import mcg_pkg::*;
(
  // Clock and bus
  input  wire logic         pclk,
  input  wire mcg_apb_rsp_t apb_rsp,
  output var  mcg_apb_req_t apb_req
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // Transfer
  // ---------------------------------------------------------------
  initial apb_req <= '0;

  // Idle edge first, so back-to-back calls never drive twice at once
  task automatic xfer(input logic w, input logic [MCG_ADDR_W-1:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    @(posedge pclk);
    apb_req <= '{1'b1, 1'b0, w, a, d, 4'hf};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    @(posedge pclk);
    while (apb_rsp.pready !== 1'b1) @(posedge pclk);
    q = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb_req <= '0;
  endtask : xfer
endmodule : mcg_host

`default_nettype wire

// >>> verif/mcg_config_sva.sv
/*
  Checker of the config bank ports: bus answer, decode, rms choice.
  Assumes a bind into mcg_config_top, one clock domain on pclk.
*/
`default_nettype none

module mcg_config_sva
  import mcg_pkg::*;
(
  // Clock and reset
  input wire logic                 pclk,
  input wire logic                 presetn,
  // Bus
  input wire mcg_apb_req_t         apb_req,
  input wire mcg_apb_rsp_t         apb_rsp,
  // Rms and decode
  input wire logic [MCG_RMS_W-1:0] nominal_voltage_value,
  input wire logic [MCG_RMS_W-1:0] measured_rms_a,
  input wire logic [MCG_RMS_W-1:0] effective_rms_a,
  input wire logic [MCG_RMS_W-1:0] effective_rms_b,
  input wire logic [MCG_RMS_W-1:0] effective_rms_c,
  input wire logic [2:0]           voltage_input_ignored,
  input wire logic                 angle_voltage_to_current,
  input wire logic                 angle_voltage_to_voltage,
  input wire logic                 angle_current_to_current,
  input wire logic                 line_frequency_select
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  wire logic acc = apb_req.psel && apb_req.penable;
  wire logic at_cm = apb_req.paddr == MCG_ADDR_COMPUTATION_MODE;
  wire logic at_gn = apb_req.paddr == MCG_ADDR_INPUT_GAIN;
  wire logic rd = acc && !apb_req.pwrite;
  wire logic wr_cm = acc && apb_req.pwrite && at_cm && apb_req.pstrb[1];
  wire logic [2:0] ang = {angle_voltage_to_current,
    angle_voltage_to_voltage, angle_current_to_current};

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_READY: assert property (apb_rsp.pready)
    else $error("pready low");
  AST_ERR: assert property (
    apb_rsp.pslverr == (acc && !at_cm && !at_gn)) else $error("slverr");
  AST_CM_RD: assert property (
    rd && at_cm |-> apb_rsp.prdata[31:15] == 17'h0) else $error("cm bits");
  AST_GN_RD: assert property (
    rd && at_gn |-> apb_rsp.prdata[31:9] == 23'h0) else $error("gain bits");
  AST_ANG_WR: assert property (
    wr_cm |=> ang == ($past(apb_req.pwdata[10:9]) == 2'h3 ? 3'h0 :
      3'h4 >> $past(apb_req.pwdata[10:9]))) else $error("angle decode");
  AST_ANG_1H: assert property ($onehot0(ang))
    else $error("angle overlap");
  AST_NOM_WR: assert property (
    wr_cm |=> voltage_input_ignored == $past(apb_req.pwdata[13:11]) &&
      line_frequency_select == $past(apb_req.pwdata[14]))
    else $error("nominal or freq bits");
  AST_RMS_A: assert property (
    voltage_input_ignored[0] |=>
      effective_rms_a == $past(nominal_voltage_value)) else $error("rms a");
  AST_RMS_B: assert property (
    voltage_input_ignored[1] |=>
      effective_rms_b == $past(nominal_voltage_value)) else $error("rms b");
  AST_RMS_C: assert property (
    voltage_input_ignored[2] |=>
      effective_rms_c == $past(nominal_voltage_value)) else $error("rms c");
  AST_RMS_M: assert property (
    !voltage_input_ignored[0] |=>
      effective_rms_a == $past(measured_rms_a)) else $error("rms measured");
endmodule : mcg_config_sva

bind mcg_config_top mcg_config_sva chk_u (
  .pclk, .presetn, .apb_req, .apb_rsp, .nominal_voltage_value,
  .measured_rms_a, .effective_rms_a, .effective_rms_b, .effective_rms_c,
  .voltage_input_ignored, .angle_voltage_to_current,
  .angle_voltage_to_voltage, .angle_current_to_current,
  .line_frequency_select
);

`default_nettype wire

// >>> verif/mcg_config_top_tb.sv
/*
  Self-checking bench of the config bank, host model on the APB side.
  Assumes mcg_host and the checker are compiled beside the design.
*/
`default_nettype none

module mcg_config_top_tb
  import mcg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic                    pclk, presetn;
  mcg_apb_req_t            req;
  mcg_apb_rsp_t            rsp;
  logic [MCG_SAMPLE_W-1:0] smp [7];
  logic [MCG_GAINED_W-1:0] scl [7];
  logic [MCG_RMS_W-1:0]    nom, mrms [3], erms [3];
  logic [2:0]              ign, pls;
  logic                    a_vi, a_vv, a_ii, lfs;
  logic [MCG_POWER_W-1:0]  pw_a [3], pw_b [3], pw_c [3];
  logic [MCG_SUM_W-1:0]    psum [3];
  int                      bad_count, checks_done, n1, n2, n3;
  logic [31:0]             q;
  logic                    e;
  logic [2:0]              f [3];

  mcg_host host_u (.pclk(pclk), .apb_rsp(rsp), .apb_req(req));

  mcg_config_top dut_u (
    .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .current_sample_a(smp[0]), .current_sample_b(smp[1]),
    .current_sample_c(smp[2]), .neutral_sample(smp[3]),
    .voltage_sample_a(smp[4]), .voltage_sample_b(smp[5]),
    .voltage_sample_c(smp[6]), .current_scaled_a(scl[0]),
    .current_scaled_b(scl[1]), .current_scaled_c(scl[2]),
    .neutral_scaled(scl[3]), .voltage_scaled_a(scl[4]),
    .voltage_scaled_b(scl[5]), .voltage_scaled_c(scl[6]),
    .nominal_voltage_value(nom), .measured_rms_a(mrms[0]),
    .measured_rms_b(mrms[1]), .measured_rms_c(mrms[2]),
    .effective_rms_a(erms[0]), .effective_rms_b(erms[1]),
    .effective_rms_c(erms[2]), .voltage_input_ignored(ign),
    .angle_voltage_to_current(a_vi), .angle_voltage_to_voltage(a_vv),
    .angle_current_to_current(a_ii), .line_frequency_select(lfs),
    .pulse_power_a(pw_a), .pulse_power_b(pw_b), .pulse_power_c(pw_c),
    .pulse_power_sum(psum), .pulse_output_one(pls[0]),
    .pulse_output_two(pls[1]), .pulse_output_three(pls[2])
  );

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    host_u.xfer(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd(input logic [19:0] a, input logic [31:0] exp);
    host_u.xfer(1'b0, a, 32'h0, q, e);
    chk(q, exp);
  endtask : rd

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out

  // ---------------------------------------------------------------
  // Clock, timeout, tests
  // ---------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Whole run is under two hundred cycles; ceiling leaves wide margin
  initial begin
    cyc(5000);
    bad_count++;
    close_out();
  end

  initial begin
    presetn <= 1'b0;
    nom <= 24'h123456;
    for (int i = 0; i < 7; i++) smp[i] <= 16'h0123 + 16'(i);
    for (int i = 0; i < 3; i++) begin
      mrms[i] <= 24'h0a0000 + 24'(i);
      pw_a[i] <= 24'h400000;
      pw_b[i] <= 24'h020000;
      pw_c[i] <= 24'h001000;
    end
    cyc(20);
    presetn <= 1'b1;
    rd(MCG_ADDR_COMPUTATION_MODE, 32'h01ff);
    rd(MCG_ADDR_INPUT_GAIN, 32'h0);
    chk(32'(a_vi), 32'h1);
    $display("test reset values done");
    wr(MCG_ADDR_COMPUTATION_MODE, 32'hffffffff);
    cyc(2);
    rd(MCG_ADDR_COMPUTATION_MODE, 32'h7fff);
    chk(32'({ign, lfs, a_vi, a_vv, a_ii}), 32'h78);
    for (int i = 0; i < 3; i++) begin
      chk(32'(erms[i]), 32'(nom));
    end
    wr(MCG_ADDR_COMPUTATION_MODE, 32'h01ff);
    cyc(2);
    for (int i = 0; i < 3; i++) chk(32'(erms[i]), 32'(mrms[i]));
    $display("test nominal voltage done");
    for (int k = 0; k < 4; k++) begin
      wr(MCG_ADDR_COMPUTATION_MODE, 32'h01ff | (k << 9));
      cyc(1);
      chk(32'({a_vi, a_vv, a_ii}), k == 3 ? 32'h0 : 32'h4 >> k);
    end
    $display("test angle select done");
    for (int c = 0; c < 8; c++) begin
      f[0] = 3'(c);
      f[1] = 3'(c + 1);
      f[2] = 3'(c + 2);
      // Spare bits written high must stay inert and read zero
      wr(MCG_ADDR_INPUT_GAIN, {16'hffff, 7'h7f, f[2], f[1], f[0]});
      cyc(3);
      rd(MCG_ADDR_INPUT_GAIN, {23'h0, f[2], f[1], f[0]});
      for (int i = 0; i < 7; i++) begin
        q = 32'(i < 3 ? f[0] : i == 3 ? f[1] : f[2]);
        if (q > 32'h4) q = 32'h0;
        chk(32'(scl[i]), 32'(smp[i]) << q);
      end
    end
    $display("test gain codes done");
    wr(MCG_ADDR_COMPUTATION_MODE, 32'h0015);
    cyc(3);
    chk(32'(psum[0]), 32'h401000);
    chk(32'(psum[1]), 32'h020000);
    chk(32'(psum[2]), 32'h0);
    n1 = 0;
    n2 = 0;
    n3 = 0;
    for (int i = 0; i < 40; i++) begin
      cyc(1);
      n1 += int'(pls[0] === 1'b1);
      n2 += int'(pls[1] === 1'b1);
      n3 += int'(pls[2] === 1'b1);
    end
    chk(32'(n1 inside {10, 11}), 32'h1);
    chk(32'(n2 < 2), 32'h1);
    chk(32'(n3), 32'h0);
    $display("test pulse sums done");
    host_u.xfer(1'b1, 20'h0, 32'hffff, q, e);
    chk(32'(e), 32'h1);
    host_u.xfer(1'b0, 20'h0, 32'h0, q, e);
    chk({q[30:0], e}, 32'h1);
    rd(MCG_ADDR_COMPUTATION_MODE, 32'h0015);
    $display("test unmapped access done");
    close_out();
  end
endmodule : mcg_config_top_tb

`default_nettype wire
